// ---- include/ssc_pkg.sv ----
// types shared by the burst sram control block
package ssc_pkg;

    // cycle kind, gray coded along idle-load-next-hold
    typedef enum logic [1:0] {
        SSC_OP_IDLE = 2'b00,
        SSC_OP_LOAD = 2'b01,
        SSC_OP_NEXT = 2'b11,
        SSC_OP_HOLD = 2'b10
    } ssc_op_e;

    // decoded synchronous command
    typedef struct packed {
        ssc_op_e op;
        logic    write;
    } ssc_cmd_s;

endpackage

// ---- include/ssc_regs.svh ----
// register offsets, fields and reset values of the burst sram control block
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define SSC_CTRL_OFS    32'h0000_0000
`define SSC_STATUS_OFS  32'h0000_0004
`define SSC_ADDR_OFS    32'h0000_0008

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define SSC_CTRL_STBY   0
`define SSC_CTRL_RST    1'b0
`define SSC_RESP_OKAY   2'b00
`define SSC_RESP_SLVERR 2'b10

`endif

// ---- rtl/ssc_top.sv ----
// control logic of a synchronous burst sram with an axi4-lite status port
`timescale 1ns/1ps
`include "ssc_regs.svh"

module ssc_top #(
    parameter int ADDR_W = 22,  // word address width
    parameter int LANES  = 4,   // byte lanes, 2 or 4
    parameter int LANE_W = 9    // bits per lane
) (
    input  wire logic                      clk,                 // 100 MHz
    input  wire logic                      srst,                // sync reset
    input  wire logic [ADDR_W-1:0]         addr,                // address pins
    input  wire logic                      primary_select_n,    // select 1
    input  wire logic                      secondary_select_n,  // select 2
    input  wire logic                      cpu_addr_strobe_n,   // cpu strobe
    input  wire logic                      ctrl_addr_strobe_n,  // ctrl strobe
    input  wire logic                      burst_step_n,        // advance
    input  wire logic                      all_lane_write_n,    // write all
    input  wire logic                      lane_write_gate_n,   // lane gate
    input  wire logic [LANES-1:0]          lane_enable_n,       // per lane
    input  wire logic                      output_enable_n,     // async oe
    input  wire logic                      linear_order_n,      // order
    input  wire logic                      register_bypass_n,   // flow/pipe
    input  wire logic                      sleep_request,       // standby
    input  wire logic [LANES*LANE_W-1:0]   dq_in,               // bus in
    output logic      [LANES*LANE_W-1:0]   dq_out,              // bus out
    output logic      [LANES-1:0]          dq_oe,               // bus drive
    output logic      [ADDR_W-1:0]         mem_addr,            // array addr
    output logic                           mem_rd,              // array read
    output logic      [LANES-1:0]          mem_wbe,             // lane writes
    output logic      [LANES*LANE_W-1:0]   mem_wdata,           // write data
    input  wire logic [LANES*LANE_W-1:0]   mem_rdata,           // read data
    input  wire logic [31:0]               s_axi_awaddr,        // aw addr
    input  wire logic                      s_axi_awvalid,       // aw valid
    output logic                           s_axi_awready,       // aw ready
    input  wire logic [31:0]               s_axi_wdata,         // w data
    input  wire logic [3:0]                s_axi_wstrb,         // w strobes
    input  wire logic                      s_axi_wvalid,        // w valid
    output logic                           s_axi_wready,        // w ready
    output logic      [1:0]                s_axi_bresp,         // b resp
    output logic                           s_axi_bvalid,        // b valid
    input  wire logic                      s_axi_bready,        // b ready
    input  wire logic [31:0]               s_axi_araddr,        // ar addr
    input  wire logic                      s_axi_arvalid,       // ar valid
    output logic                           s_axi_arready,       // ar ready
    output logic      [31:0]               s_axi_rdata,         // r data
    output logic      [1:0]                s_axi_rresp,         // r resp
    output logic                           s_axi_rvalid,        // r valid
    input  wire logic                      s_axi_rready         // r ready
);
    import ssc_pkg::*;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------

    // low address bits of a burst position
    function automatic logic [1:0] burst_low(
        input logic [1:0] start,
        input logic [1:0] step,
        input logic       linear
    );
        burst_low = linear ? 2'(start + step) : (start ^ step);
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic              ctrl_stby;
    logic [ADDR_W-3:0] upper;
    logic [1:0]        start;
    logic [1:0]        step;
    ssc_op_e           last_op;
    logic              rd_s2;
    logic [LANES*LANE_W-1:0] rdat_s1;
    logic              drive_q;

    // ---------------------------------------------------------------
    // synchronous decode
    // ---------------------------------------------------------------

    // write condition; a cleared gate with no lanes still writes
    wire logic wr_cond = ~all_lane_write_n | ~lane_write_gate_n;

    // per-lane gating, lane count follows the configuration
    wire logic [LANES-1:0] gate_mask = ~lane_write_gate_n ? ~lane_enable_n : '0;
    wire logic [LANES-1:0] lane_mask = ~all_lane_write_n ? '1 : gate_mask;

    wire logic strobe_lo = ~cpu_addr_strobe_n | ~ctrl_addr_strobe_n;

    wire logic desel = (primary_select_n & ~ctrl_addr_strobe_n)
                     | (~primary_select_n & secondary_select_n & strobe_lo);

    // tied strobes reduce to plain loads and steps
    // begin burst, cpu strobe forces a read
    wire logic load    = ~primary_select_n & ~secondary_select_n & strobe_lo;
    wire logic load_wr = load & cpu_addr_strobe_n & wr_cond;

    // sleep pin or software standby; pads hold the pin defaults
    wire logic standby = sleep_request | ctrl_stby;
    wire logic linear  = ~linear_order_n;

    // every remaining combination is a continue or suspend
    ssc_cmd_s cmd;
    wire logic access = (cmd.op != SSC_OP_IDLE);
    assign cmd.op    = (standby | desel) ? SSC_OP_IDLE :
                       load              ? SSC_OP_LOAD :
                       burst_step_n      ? SSC_OP_HOLD : SSC_OP_NEXT;
    assign cmd.write = (cmd.op == SSC_OP_LOAD) ? load_wr : (access & wr_cond);

    // ---------------------------------------------------------------
    // burst counter
    // ---------------------------------------------------------------

    // advance only on next, output enable has no say
    wire logic [1:0] next_step = (cmd.op == SSC_OP_LOAD) ? 2'h0 :
                                 (cmd.op == SSC_OP_NEXT) ? 2'(step + 2'h1) : step;
    wire logic [1:0] next_start = (cmd.op == SSC_OP_LOAD) ? addr[1:0] : start;
    wire logic [ADDR_W-3:0] next_upper =
        (cmd.op == SSC_OP_LOAD) ? addr[ADDR_W-1:2] : upper;
    wire logic [ADDR_W-1:0] next_addr =
        {next_upper, burst_low(next_start, next_step, linear)};

    // counter registers; no address moves on a deselect
    always_ff @(posedge clk) begin
        if (srst) begin
            upper   <= '0;
            start   <= 2'h0;
            step    <= 2'h0;
            last_op <= SSC_OP_IDLE;
        end else begin
            upper   <= next_upper;
            start   <= next_start;
            step    <= next_step;
            last_op <= cmd.op;
        end
    end

    // ---------------------------------------------------------------
    // array side
    // ---------------------------------------------------------------

    // write lanes, no access when deselected
    always_ff @(posedge clk) begin
        if (srst) begin
            mem_addr  <= '0;
            mem_rd    <= 1'b0;
            mem_wbe   <= '0;
            mem_wdata <= '0;
        end else begin
            mem_addr  <= access ? next_addr : mem_addr;
            mem_rd    <= access & ~cmd.write;
            mem_wbe   <= (access & cmd.write) ? lane_mask : '0;
            mem_wdata <= (access & cmd.write) ? dq_in : mem_wdata;
        end
    end

    // ---------------------------------------------------------------
    // output pipeline
    // ---------------------------------------------------------------

    // flow-through drops one stage; deselects ride the same pipe
    wire logic rd_tap = register_bypass_n ? rd_s2 : mem_rd;
    wire logic [LANES*LANE_W-1:0] dat_tap = register_bypass_n ? rdat_s1 : mem_rdata;
    // a sampled write kills drive at once to avoid contention
    wire logic next_drive = rd_tap & ~(access & cmd.write) & ~standby;

    // deselect reaches the drivers at the read depth
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_s2   <= 1'b0;
            rdat_s1 <= '0;
            drive_q <= 1'b0;
            dq_out  <= '0;
        end else begin
            rd_s2   <= mem_rd;
            rdat_s1 <= mem_rdata;
            drive_q <= next_drive;
            dq_out  <= dat_tap;
        end
    end

    // all lanes together; output enable gates without a clock
    assign dq_oe = {LANES{drive_q & ~output_enable_n}};

    // ---------------------------------------------------------------
    // axi4-lite slave
    // ---------------------------------------------------------------
    logic        aw_got;
    logic        w_got;
    logic [31:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;

    // both halves may arrive in either order
    wire logic aw_hs  = s_axi_awvalid & s_axi_awready;
    wire logic w_hs   = s_axi_wvalid & s_axi_wready;
    wire logic do_wr  = (aw_got | aw_hs) & (w_got | w_hs) & ~s_axi_bvalid;
    wire logic [31:0] wa = aw_hs ? s_axi_awaddr : aw_addr_q;
    wire logic [31:0] wd = w_hs ? s_axi_wdata : w_data_q;
    wire logic [3:0]  ws = w_hs ? s_axi_wstrb : w_strb_q;
    wire logic next_aw_got = (aw_got | aw_hs) & ~do_wr;
    wire logic next_w_got  = (w_got | w_hs) & ~do_wr;
    wire logic next_bvalid = do_wr | (s_axi_bvalid & ~s_axi_bready);
    wire logic wa_ok = (wa == `SSC_CTRL_OFS) | (wa == `SSC_STATUS_OFS)
                     | (wa == `SSC_ADDR_OFS);
    wire logic ctrl_wr = do_wr & (wa == `SSC_CTRL_OFS) & ws[0];

    // write channel registers; ready drops while a response waits
    always_ff @(posedge clk) begin
        if (srst) begin
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr_q     <= '0;
            w_data_q      <= '0;
            w_strb_q      <= '0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SSC_RESP_OKAY;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            ctrl_stby     <= `SSC_CTRL_RST;
        end else begin
            aw_got        <= next_aw_got;
            w_got         <= next_w_got;
            aw_addr_q     <= wa;
            w_data_q      <= wd;
            w_strb_q      <= ws;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= do_wr ? (wa_ok ? `SSC_RESP_OKAY : `SSC_RESP_SLVERR)
                                   : s_axi_bresp;
            s_axi_awready <= ~next_aw_got & ~next_bvalid;
            s_axi_wready  <= ~next_w_got & ~next_bvalid;
            ctrl_stby     <= ctrl_wr ? wd[`SSC_CTRL_STBY] : ctrl_stby;
        end
    end

    // read decode; status shows live mode pins and burst position
    wire logic do_rd       = s_axi_arvalid & s_axi_arready;
    wire logic next_rvalid = do_rd | (s_axi_rvalid & ~s_axi_rready);
    wire logic [31:0] status_word = {22'h0, drive_q, step, start, last_op,
                                     ~linear, register_bypass_n, standby};
    wire logic [31:0] rd_word =
        (s_axi_araddr == `SSC_CTRL_OFS)   ? {31'h0, ctrl_stby} :
        (s_axi_araddr == `SSC_STATUS_OFS) ? status_word :
        (s_axi_araddr == `SSC_ADDR_OFS)   ? 32'(mem_addr) : 32'h0;
    wire logic ra_ok = (s_axi_araddr == `SSC_CTRL_OFS)
                     | (s_axi_araddr == `SSC_STATUS_OFS)
                     | (s_axi_araddr == `SSC_ADDR_OFS);

    // read channel registers
    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `SSC_RESP_OKAY;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= do_rd ? rd_word : s_axi_rdata;
            s_axi_rresp   <= do_rd ? (ra_ok ? `SSC_RESP_OKAY : `SSC_RESP_SLVERR)
                                   : s_axi_rresp;
            s_axi_arready <= ~next_rvalid;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking ast_clk @(posedge clk);
    endclocking
    default disable iff (srst);

    wire logic rd_cyc = access & ~cmd.write;
    wire logic wr_cyc = access & cmd.write;

    // decode and counter checks
    AST_DESEL_IDLE: assert property (desel |=> !mem_rd && mem_wbe == '0)
        else $error("deselect caused an array access");
    AST_LOAD_READ: assert property (load && !cpu_addr_strobe_n && !standby
        |=> mem_rd && mem_addr == $past(addr))
        else $error("processor strobe load did not read at pin address");
    AST_LOAD_WRITE: assert property (load_wr && !standby
        |=> mem_wbe == $past(lane_mask) && mem_addr == $past(addr))
        else $error("controller strobe write not started at pin address");
    AST_ALL_LANES: assert property (wr_cyc && !all_lane_write_n
        |=> mem_wbe == '1)
        else $error("all-lane write missed a lane");
    AST_LINEAR_STEP: assert property (cmd.op == SSC_OP_NEXT && linear
        |=> mem_addr[1:0] == 2'($past(mem_addr[1:0]) + 2'h1))
        else $error("linear burst did not add one");
    AST_HOLD_ADDR: assert property (cmd.op == SSC_OP_HOLD
        |=> $stable(mem_addr) && mem_rd == !$past(wr_cond))
        else $error("suspend moved the burst address");
    AST_WRAP: assert property (cmd.op == SSC_OP_LOAD
        ##1 (cmd.op == SSC_OP_NEXT && $stable(linear_order_n))[*4]
        |=> mem_addr == $past(mem_addr, 4))
        else $error("burst did not wrap to its start on the fifth clock");

    // output drive checks
    AST_WRITE_HIZ: assert property (wr_cyc |=> dq_oe == '0)
        else $error("data drivers on during a write");
    AST_OE_ASYNC: assert property (output_enable_n |-> dq_oe == '0)
        else $error("output enable high left drivers on");
    AST_LANES_TOGETHER: assert property (rd_cyc && lane_enable_n != '1
        && register_bypass_n ##1 register_bypass_n
        ##1 (register_bypass_n && !wr_cyc && !standby)
        |=> dq_oe == {LANES{!output_enable_n}})
        else $error("read drove only some lanes");
    AST_FLOW_READ: assert property (rd_cyc && !register_bypass_n
        ##1 (!register_bypass_n && !wr_cyc && !standby) |=> drive_q)
        else $error("flow-through read not driven after one edge");
    AST_PIPE_READ: assert property (rd_cyc && register_bypass_n
        ##1 register_bypass_n
        ##1 (register_bypass_n && !wr_cyc && !standby) |=> drive_q)
        else $error("pipelined read not driven after two edges");
    AST_DCD_OFF: assert property ((desel && register_bypass_n)
        ##1 register_bypass_n ##1 register_bypass_n |=> !drive_q)
        else $error("deselect did not turn drivers off at pipeline depth");

    // main scenarios
    COV_BURST_READ: cover property (cmd.op == SSC_OP_LOAD && rd_cyc
        ##1 (cmd.op == SSC_OP_NEXT)[*3]);
    COV_DUMMY_READ: cover property (rd_cyc && output_enable_n ##1 wr_cyc);
    COV_SLEEP: cover property (sleep_request ##1 !sleep_request);
    COV_LANE_WRITE: cover property (wr_cyc && all_lane_write_n
        && !lane_write_gate_n);

endmodule

// ---- tb/ssc_host_model.sv ----
// host controller model that drives the burst sram pins
`timescale 1ns/1ps

module ssc_host_model (
    input  wire logic        clk,                 // bench clock
    output logic             primary_select_n,    // select one
    output logic             secondary_select_n,  // select two
    output logic             cpu_addr_strobe_n,   // cpu strobe
    output logic             ctrl_addr_strobe_n,  // ctrl strobe
    output logic             burst_step_n,        // advance
    output logic             all_lane_write_n,    // all lanes
    output logic             lane_write_gate_n,   // lane gate
    output logic [3:0]       lane_enable_n,       // lane enables
    output logic [21:0]      addr,                // address
    output logic [35:0]      dq_in                // write data
);
    initial begin
        {primary_select_n, secondary_select_n, cpu_addr_strobe_n} = 3'b101;
        {ctrl_addr_strobe_n, burst_step_n, all_lane_write_n, lane_write_gate_n} = 4'b0111;
        lane_enable_n = 4'hf;
        addr = '0;
        dq_in = '0;
    end

    // caller picks strobes, lane enables and address; output enable is not driven here
    // data changes every cycle so a stale bus never looks valid
    task automatic drive(input logic [6:0] c, input logic [3:0] be, input logic [21:0] a,
                         output logic [35:0] d);
        d = {4'($urandom), $urandom};
        {primary_select_n, secondary_select_n, cpu_addr_strobe_n, ctrl_addr_strobe_n,
         burst_step_n, all_lane_write_n, lane_write_gate_n} <= c;
        lane_enable_n <= be;
        addr <= a;
        dq_in <= d;
    endtask
endmodule

// ---- tb/tb_sync_burst_sram_control.sv ----
// self-checking bench of the burst sram control block
`timescale 1ns/1ps
`include "ssc_regs.svh"

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end

module tb_sync_burst_sram_control;
    import ssc_pkg::*;

    logic        clk, srst, output_enable_n, linear_order_n, register_bypass_n;
    logic        sleep_request, primary_select_n, secondary_select_n, cpu_addr_strobe_n;
    logic        ctrl_addr_strobe_n, burst_step_n, all_lane_write_n, lane_write_gate_n;
    logic        mem_rd, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [3:0]  lane_enable_n, dq_oe, mem_wbe, s_axi_wstrb;
    logic [21:0] addr, mem_addr, a;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
    logic [35:0] dq_in, dq_out, mem_wdata, mem_rdata;
    int          errors, checks, m_start, m_step, m_up, lin, stby;

    ssc_top ssc_top_i (.clk, .srst, .addr, .primary_select_n, .secondary_select_n,
        .cpu_addr_strobe_n, .ctrl_addr_strobe_n, .burst_step_n, .all_lane_write_n,
        .lane_write_gate_n, .lane_enable_n, .output_enable_n, .linear_order_n,
        .register_bypass_n, .sleep_request, .dq_in, .dq_out, .dq_oe, .mem_addr, .mem_rd,
        .mem_wbe, .mem_wdata, .mem_rdata, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    ssc_host_model ssc_host_model_i (.clk, .primary_select_n, .secondary_select_n,
        .cpu_addr_strobe_n, .ctrl_addr_strobe_n, .burst_step_n, .all_lane_write_n,
        .lane_write_gate_n, .lane_enable_n, .addr, .dq_in);

    // array stand-in: words differ in their low 18 address bits so a wrong address shows
    assign mem_rdata = {mem_addr[17:0], ~mem_addr[17:0]};

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // --------------------
    // helpers
    // --------------------
    function automatic logic [21:0] exp_addr();
        return {20'(m_up), 2'(lin ? m_start + m_step : m_start ^ m_step)};
    endfunction

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // write: address and data offered together, each released once taken
    task automatic axi_wr(input logic [31:0] ad, input logic [31:0] dat, output logic [1:0] r);
        bit aw, w;
        aw = 0;
        w = 0;
        s_axi_awaddr <= ad;
        s_axi_wdata <= dat;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            aw = aw | (s_axi_awready === 1'b1);
            w = w | (s_axi_wready === 1'b1);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic axi_rd(input logic [31:0] ad, output logic [31:0] dat, output logic [1:0] r);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        dat = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask

    // one pin cycle {sleep,sel1,sel2,cpu,ctrl,step,all,gate}; model then compare
    task automatic cyc(input logic [7:0] c, input logic [3:0] be, input logic [21:0] ad,
                       input int eoe = -1, input logic [35:0] edat = '0);
        logic        desel, iswr, ld;
        logic [3:0]  wbe;
        logic [21:0] ea;
        logic [35:0] d;
        desel = c[7] | stby[0] | (!c[6] & c[5] & !(c[4] & c[3])) | (c[6] & !c[3]);
        ld = !desel & !c[6] & !(c[4] & c[3]);
        wbe = !c[1] ? 4'hf : (!c[0] ? ~be : 4'h0);
        iswr = !desel & (!c[1] | !c[0]) & (!ld | c[4]);
        if (ld) begin
            m_start = int'(ad[1:0]);
            m_step = 0;
            m_up = int'(ad[21:2]);
        end else if (!desel && !c[2]) begin
            m_step = (m_step + 1) % 4;
        end
        ea = exp_addr();
        sleep_request <= c[7];
        ssc_host_model_i.drive(c[6:0], be, ad, d);
        @(posedge clk);
        fork
            begin
                #1;
                `CHK("mem_addr", ea, mem_addr)
                `CHK("mem_rd", !desel & !iswr, mem_rd)
                `CHK("mem_wbe", iswr ? wbe : 4'h0, mem_wbe)
                if (iswr) `CHK("mem_wdata", d, mem_wdata)
                if (iswr) `CHK("dq_oe write", 4'h0, dq_oe)
                if (eoe >= 0) `CHK("dq_oe", eoe ? 4'hf : 4'h0, dq_oe)
                if (eoe == 1) `CHK("dq_out", edat, dq_out)
            end
        join_none
    endtask

    // watchdog, far beyond the hundred-odd cycles the run needs
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        print_verdict();
    end

    // --------------------
    // main sequence
    // --------------------
    initial begin
        srst = 1'b1;
        {output_enable_n, linear_order_n, register_bypass_n, sleep_request} = 4'b0110;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hf;
        void'($urandom(32'hfb0c));
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        axi_rd(`SSC_CTRL_OFS, rd, rs);
        `CHK("ctrl reset", 32'h0, rd)
        axi_rd(`SSC_STATUS_OFS, rd, rs);
        `CHK("mode pins", 2'b11, rd[2:1])
        axi_rd(32'h0000_0040, rd, rs);
        `CHK("unmapped rresp", `SSC_RESP_SLVERR, rs)
        axi_wr(32'h0000_0040, 32'h1, rs);
        `CHK("unmapped bresp", `SSC_RESP_SLVERR, rs)
        axi_wr(`SSC_CTRL_OFS, 32'h1, rs);
        stby = 1;
        cyc(8'h0f, 4'hf, 22'h5);
        cyc(8'h57, 4'hf, 22'h5);
        axi_rd(`SSC_STATUS_OFS, rd, rs);
        `CHK("standby flag", 1'b1, rd[0])
        axi_wr(`SSC_CTRL_OFS, 32'h0, rs);
        stby = 0;
        // both orders, every start; dummy reads then writes without a deselect
        output_enable_n <= 1'b1;
        for (int o = 0; o < 2; o++) begin
            lin = 1 - o;
            linear_order_n <= o[0];
            for (int s = 0; s < 4; s++) begin
                a = {20'($urandom), 2'(s)};
                cyc(8'h0f, 4'hf, a);
                for (int i = 1; i < 5; i++) cyc(i[0] ? 8'h4b : 8'h1b, 4'hf, a);
                cyc(8'h4f, 4'hf, a);
                cyc(8'h1d, 4'hf, a);
                cyc(8'h1a, 4'($urandom), a);
            end
        end
        // begin-burst writes and reads, deselect forms, sleep
        output_enable_n <= 1'b0;
        cyc(8'h57, 4'hf, a);
        a = 22'($urandom);
        cyc(8'h15, 4'h0, a);
        cyc(8'h16, 4'($urandom), a);
        cyc(8'h0d, 4'h0, a);
        cyc(8'h17, 4'h0, a);
        cyc(8'h37, 4'hf, a);
        cyc(8'h2f, 4'hf, a);
        cyc(8'h8f, 4'hf, a);
        // read output latency and turn-off, pipelined then flow-through
        for (int f = 1; f >= 0; f--) begin
            register_bypass_n <= f[0];
            a = 22'($urandom);
            cyc(8'h57, 4'hf, a);
            cyc(8'h0f, 4'hf, a);
            for (int j = 1; j < 4; j++) begin
                cyc(8'h57, 4'hf, a, int'(j == 1 + f), {a[17:0], ~a[17:0]});
                if (j == 1 + f) begin
                    #3;
                    output_enable_n = 1'b1;
                    #1;
                    `CHK("dq_oe forced off", 4'h0, dq_oe)
                    output_enable_n = 1'b0;
                    @(posedge clk);
                end
            end
        end
        axi_rd(`SSC_ADDR_OFS, rd, rs);
        `CHK("addr reg", exp_addr(), rd[21:0])
        print_verdict();
    end
endmodule
